// File: core/abu_pkg.sv
// package for the address breakpoint unit
// assumes word-wide AHB-Lite register access, one clock domain
package abu_pkg;
	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [15:0] IDX_ADDR_HIGH = 16'hfe0c; // break_address_high
	localparam logic [15:0] IDX_ADDR_LOW = 16'hfe0d; // break_address_low
	localparam logic [15:0] IDX_STATUS_CTRL = 16'hfe0e; // break_status_control
	localparam logic [15:0] IDX_FLAG_CTRL = 16'hfe0f; // flag_control_register
	localparam logic [15:0] IDX_WAIT_STATUS = 16'hfe10; // wait exit status
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hfe11; // sticky events, write 1 clears
	localparam logic [15:0] IDX_IRQ_MASK = 16'hfe12; // event mask

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_ENABLE = 7; // breakpoint_enable
	localparam int BIT_ACTIVE = 6; // breakpoint_active_flag
	localparam int BIT_FCE = 7; // flag_clear_enable
	localparam int BIT_WAIT_EXIT = 1; // wait_exit_by_break_flag
	localparam int EV_MATCH = 0; // address match break
	localparam int EV_SOFT = 1; // software break
	localparam int EV_WAIT = 2; // wait exited by break
	localparam int NUM_EV = 3; // number of events

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00; // all registers
	localparam logic [2:0] RST_EV = 3'h0; // status and mask

	// ----------------------------------------
	// ahb constants
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // nonsequential
	localparam logic HRESP_OKAY = 1'h0; // always okay

	// ----------------------------------------
	// types
	// ----------------------------------------
	// cpu-side inputs travelling together
	typedef struct packed {
		logic [15:0] addr; // cpu-generated address
		logic addr_valid; // address valid this bus cycle
		logic in_wait; // cpu in wait mode
		logic in_stop; // cpu in stop mode
		logic opcode_taken; // pulse: cpu took the break opcode
		logic return_done; // pulse: return from break routine
	} abu_cpu_t;

	// break sequence states, gray along idle-request-break
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_REQ = 2'h1,
		ST_BRK = 2'h3
	} abu_state_t;
endpackage : abu_pkg

// File: core/abu_cmp.sv
// address comparator of the breakpoint unit
// assumes the cpu address is synchronous to hclk
`timescale 1ns/10ps
module abu_cmp (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// compare inputs
	input wire logic [15:0] cpu_addr,
	input wire logic addr_valid,
	input wire logic enable,
	input wire logic in_stop,
	input wire logic [15:0] brk_addr,
	// result
	output logic hit_q
);
	// ----------------------------------------
	// match register
	// ----------------------------------------
	// full equality each bus cycle, gated by enable, dead in stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= addr_valid && enable && !in_stop && (cpu_addr == brk_addr);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cmp_exact;
		@(posedge hclk) disable iff (!hresetn)
		(addr_valid && enable && !in_stop && cpu_addr == brk_addr) |=> hit_q;
	endproperty
	a_cmp_exact: assert property (p_cmp_exact) else $error("match not flagged");

	property p_cmp_disabled;
		@(posedge hclk) disable iff (!hresetn)
		(!enable || in_stop) |=> !hit_q;
	endproperty
	a_cmp_disabled: assert property (p_cmp_disabled) else $error("hit while disabled");
endmodule : abu_cmp

// File: core/abu_top.sv
// address breakpoint unit: registers, break sequence, cpu signals
// Functional notes
// - address match raises break request
// - writing one to active flag breaks
// - match on last cycle breaks immediately
// - timer counter stopped during break
// - watchdog off in break under test voltage
// - flag clear enable gates peripheral clears
// - works in wait; records wait exit
// - address match inactive in stop; registers kept
// - address bytes at fe0c/fe0d, reset zero
// - status control layout, low bits zero
// - enable gates match breaks; reset clears
// - match sets active; write zero clears
// assumes a single AHB-Lite master and a cpu on the same clock
`timescale 1ns/10ps
module abu_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// cpu side
	input wire abu_pkg::abu_cpu_t cpu,
	input wire logic test_voltage_on_reset,
	output logic break_request,
	output logic timer_stop,
	output logic watchdog_disable,
	output logic flag_clear_allow,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] addr_high_q; // break_address_high
	logic [7:0] addr_low_q; // break_address_low
	logic enable_q; // breakpoint_enable
	logic active_q; // breakpoint_active_flag
	logic fce_q; // flag_clear_enable
	logic wait_exit_q; // wait_exit_by_break_flag
	logic [2:0] sts_q; // sticky events
	logic [2:0] mask_q; // event mask
	logic wr_pend_q; // write data phase pending
	logic rd_pend_q; // read data phase pending
	logic [29:0] wr_idx_q; // write word index
	logic [29:0] rd_idx_q; // read word index
	logic [31:0] hrdata_q; // read data
	logic hreadyout_q; // ready
	logic req_q; // break request to cpu
	logic tstop_q; // timer stop
	logic wdog_q; // watchdog disable
	logic fclr_q; // peripheral clear allow
	logic irq_q; // interrupt level
	abu_pkg::abu_state_t state_q; // break sequence
	abu_pkg::abu_state_t state_d; // next state
	logic cmp_hit; // address match this cycle
	logic accept; // address phase taken
	logic [7:0] wbyte; // written byte
	logic soft_brk; // software break write
	logic brk_ev; // any break event
	logic [2:0] ev; // event vector

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// write strobe for one register index
	function automatic logic wr_hit(input logic pend, input logic [29:0] idx,
		input logic [15:0] reg_idx);
		wr_hit = pend && (idx == {14'h0000, reg_idx});
	endfunction : wr_hit

	// ----------------------------------------
	// comparator
	// ----------------------------------------
	abu_cmp u_cmp (
		.hclk(hclk),
		.hresetn(hresetn),
		.cpu_addr(cpu.addr),
		.addr_valid(cpu.addr_valid),
		.enable(enable_q),
		.in_stop(cpu.in_stop),
		.brk_addr({addr_high_q, addr_low_q}),
		.hit_q(cmp_hit)
	);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign accept = hsel && hready && (htrans == abu_pkg::HTRANS_NONSEQ);
	assign wbyte = hwdata[7:0];
	// writing one to the active flag is a break request
	assign soft_brk = wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_STATUS_CTRL)
		&& wbyte[abu_pkg::BIT_ACTIVE];
	assign brk_ev = cmp_hit || soft_brk;
	assign ev = {brk_ev && cpu.in_wait, soft_brk, cmp_hit};

	// address phase capture; reads get one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_idx_q <= 30'h00000000;
			rd_idx_q <= 30'h00000000;
		end else begin
			wr_pend_q <= accept && hwrite;
			rd_pend_q <= accept && !hwrite;
			if (accept) begin
				wr_idx_q <= haddr[31:2];
				rd_idx_q <= haddr[31:2];
			end
		end
	end

	// read data and ready; unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
		end else if (accept && !hwrite) begin
			hreadyout_q <= 1'b0;
		end else if (rd_pend_q) begin
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
			unique case (rd_idx_q)
				{14'h0000, abu_pkg::IDX_ADDR_HIGH}: hrdata_q[7:0] <= addr_high_q;
				{14'h0000, abu_pkg::IDX_ADDR_LOW}: hrdata_q[7:0] <= addr_low_q;
				{14'h0000, abu_pkg::IDX_STATUS_CTRL}: begin
					// low six bits read zero
					hrdata_q[7:0] <= {enable_q, active_q, 6'h00};
				end
				{14'h0000, abu_pkg::IDX_FLAG_CTRL}: hrdata_q[abu_pkg::BIT_FCE] <= fce_q;
				{14'h0000, abu_pkg::IDX_WAIT_STATUS}: begin
					hrdata_q[abu_pkg::BIT_WAIT_EXIT] <= wait_exit_q;
				end
				{14'h0000, abu_pkg::IDX_IRQ_STATUS}: hrdata_q[2:0] <= sts_q;
				{14'h0000, abu_pkg::IDX_IRQ_MASK}: hrdata_q[2:0] <= mask_q;
				default: hrdata_q <= 32'h00000000; // unmapped
			endcase
		end
	end

	// ----------------------------------------
	// registers written by software
	// ----------------------------------------
	// break address bytes; stop mode does not touch them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_high_q <= abu_pkg::RST_BYTE;
			addr_low_q <= abu_pkg::RST_BYTE;
		end else begin
			if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_ADDR_HIGH)) begin
				addr_high_q <= wbyte;
			end
			if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_ADDR_LOW)) begin
				addr_low_q <= wbyte;
			end
		end
	end
	// enable bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= 1'b0;
		end else if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_STATUS_CTRL)) begin
			enable_q <= wbyte[abu_pkg::BIT_ENABLE];
		end
	end
	// active flag: match sets, written value otherwise; set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_q <= 1'b0;
		end else if (cmp_hit) begin
			active_q <= 1'b1;
		end else if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_STATUS_CTRL)) begin
			active_q <= wbyte[abu_pkg::BIT_ACTIVE];
		end
	end
	// flag clear enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fce_q <= 1'b0;
		end else if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_FLAG_CTRL)) begin
			fce_q <= wbyte[abu_pkg::BIT_FCE];
		end
	end
	// wait exit flag: break while waiting sets, write zero clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_exit_q <= 1'b0;
		end else if (brk_ev && cpu.in_wait) begin
			wait_exit_q <= 1'b1;
		end else if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_WAIT_STATUS)
			&& !wbyte[abu_pkg::BIT_WAIT_EXIT]) begin
			wait_exit_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// break sequence
	// ----------------------------------------
	// request until the cpu takes the opcode, break until return
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			abu_pkg::ST_IDLE: begin
				if (brk_ev) begin
					state_d = abu_pkg::ST_REQ;
				end
			end
			abu_pkg::ST_REQ: begin
				if (cpu.opcode_taken) begin
					state_d = abu_pkg::ST_BRK;
				end
			end
			abu_pkg::ST_BRK: begin
				if (cpu.return_done) begin
					state_d = abu_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = abu_pkg::ST_IDLE; // illegal code
			end
		endcase
	end
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= abu_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	// request output, no extra delay after the match cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= 1'b0;
		end else begin
			req_q <= (state_d == abu_pkg::ST_REQ);
		end
	end
	// side effects during break
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tstop_q <= 1'b0;
			wdog_q <= 1'b0;
			fclr_q <= 1'b1;
		end else begin
			tstop_q <= (state_d == abu_pkg::ST_BRK);
			wdog_q <= (state_d == abu_pkg::ST_BRK) && test_voltage_on_reset;
			fclr_q <= (state_d != abu_pkg::ST_BRK) || fce_q;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// sticky status, write one clears, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sts_q <= abu_pkg::RST_EV;
			mask_q <= abu_pkg::RST_EV;
		end else begin
			for (int i = 0; i < abu_pkg::NUM_EV; i++) begin
				if (ev[i]) begin
					sts_q[i] <= 1'b1;
				end else if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_IRQ_STATUS)
					&& wbyte[i]) begin
					sts_q[i] <= 1'b0;
				end
			end
			if (wr_hit(wr_pend_q, wr_idx_q, abu_pkg::IDX_IRQ_MASK)) begin
				mask_q <= wbyte[2:0];
			end
		end
	end
	// interrupt level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_q & mask_q);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = abu_pkg::HRESP_OKAY;
	assign break_request = req_q;
	assign timer_stop = tstop_q;
	assign watchdog_disable = wdog_q;
	assign flag_clear_allow = fclr_q;
	assign irq = irq_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_req_open;
		req_q ##1 cpu.opcode_taken;
	endsequence
	property p_match_req;
		@(posedge hclk) disable iff (!hresetn)
		(cmp_hit && state_q == abu_pkg::ST_IDLE) |=> req_q;
	endproperty
	a_match_req: assert property (p_match_req) else $error("match without request");
	property p_soft_req;
		@(posedge hclk) disable iff (!hresetn)
		(soft_brk && state_q == abu_pkg::ST_IDLE) |=> (req_q && active_q);
	endproperty
	a_soft_req: assert property (p_soft_req) else $error("soft break lost");
	property p_timer_stop;
		@(posedge hclk) disable iff (!hresetn)
		s_req_open |=> (timer_stop && !req_q);
	endproperty
	a_timer_stop: assert property (p_timer_stop) else $error("timer runs in break");
	property p_wdog;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == abu_pkg::ST_BRK && !cpu.return_done && test_voltage_on_reset)
			|=> watchdog_disable;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog live in break");
	// the output lags the enable bit by one edge, so the bit must be steady
	property p_fclr;
		@(posedge hclk) disable iff (!hresetn)
		(timer_stop && !fce_q && $stable(fce_q) && $stable(state_q)) |-> !flag_clear_allow;
	endproperty
	a_fclr: assert property (p_fclr) else $error("clear allowed in break");
	property p_wait_flag;
		@(posedge hclk) disable iff (!hresetn)
		(brk_ev && cpu.in_wait) |=> (wait_exit_q && sts_q[abu_pkg::EV_WAIT]);
	endproperty
	a_wait_flag: assert property (p_wait_flag) else $error("wait exit not recorded");
	property p_stop_keep;
		@(posedge hclk) disable iff (!hresetn)
		(cpu.in_stop && !wr_pend_q) |=> ($stable(addr_high_q) && $stable(addr_low_q));
	endproperty
	a_stop_keep: assert property (p_stop_keep) else $error("stop changed address");
	property p_active_set;
		@(posedge hclk) disable iff (!hresetn)
		cmp_hit |=> active_q;
	endproperty
	a_active_set: assert property (p_active_set) else $error("active flag not set");
	property p_rti_end;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == abu_pkg::ST_BRK && cpu.return_done) |=> !timer_stop;
	endproperty
	a_rti_end: assert property (p_rti_end) else $error("break not ended");
	property p_ctrl_read;
		@(posedge hclk) disable iff (!hresetn)
		(rd_pend_q && rd_idx_q == {14'h0000, abu_pkg::IDX_STATUS_CTRL})
			|=> (hrdata[5:0] == 6'h00 && hrdata[7] == $past(enable_q));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("bad control readback");
endmodule : abu_top

// File: testbench/abu_cpu_model.sv
// behavioural cpu facing the breakpoint unit: fetches, takes breaks, returns
// assumes abu_pkg is compiled first and one clock shared with the unit
`timescale 1ns/10ps
module abu_cpu_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// commands from the bench
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_on,
	input wire logic wait_on,
	input wire logic stop_on,
	input wire logic slow,
	input wire logic monitor,
	// link to the unit
	input wire logic break_request,
	input wire logic timer_stop,
	output abu_pkg::abu_cpu_t cpu
);
	int cnt_q; // cycles spent in the current phase
	logic [15:0] pc_q; // program counter after vectoring
	// ----------------------------------------
	// bus cycles and break handling
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu <= '0;
			cnt_q <= 0;
			pc_q <= 16'h0000;
		end else begin
			cpu.addr_valid <= fetch_on;
			cpu.addr <= fetch_on ? fetch_addr : ~cpu.addr; // idle bus keeps toggling
			cpu.in_wait <= wait_on;
			cpu.in_stop <= stop_on;
			cpu.opcode_taken <= 1'b0;
			cpu.return_done <= 1'b0;
			if (break_request && !cpu.opcode_taken) begin
				// finish the instruction, then load the break opcode
				cnt_q <= cnt_q + 1;
				if (cnt_q >= (slow ? 5 : 0)) begin
					cpu.opcode_taken <= 1'b1;
					cnt_q <= 0;
					pc_q <= monitor ? 16'hfefc : 16'hfffc; // vector pair
				end
			end else if (timer_stop) begin
				cnt_q <= cnt_q + 1;
				cpu.return_done <= (cnt_q == 4); // return ends the break
			end else begin
				cnt_q <= 0;
			end
		end
	end
endmodule : abu_cpu_model

// File: testbench/address_breakpoint_unit_bench.sv
// self-checking bench of the breakpoint unit with a register model
// assumes abu_pkg, abu_top and abu_cpu_model are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module address_breakpoint_unit_bench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic hclk;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	abu_pkg::abu_cpu_t cpu;
	logic tv = 1'b0; // test voltage on reset pin
	logic break_request, timer_stop, watchdog_disable, flag_clear_allow, irq;
	logic [15:0] fa = 16'h0; // cpu fetch address
	logic fon = 1'b0, won = 1'b0, son = 1'b0, slow = 1'b0, mon = 1'b0;
	int n_fail = 0;
	int comparisons = 0;
	logic [15:0] lf = 16'h0021; // random state
	logic [7:0] mdl [logic [15:0]]; // register model
	// ----------------------------------------
	// clock and instances
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	abu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cpu(cpu), .test_voltage_on_reset(tv), .break_request(break_request),
		.timer_stop(timer_stop), .watchdog_disable(watchdog_disable),
		.flag_clear_allow(flag_clear_allow), .irq(irq));
	abu_cpu_model cpu_m (.hclk(hclk), .hresetn(hresetn), .fetch_addr(fa),
		.fetch_on(fon), .wait_on(won), .stop_on(son), .slow(slow), .monitor(mon),
		.break_request(break_request), .timer_stop(timer_stop), .cpu(cpu));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] ev(input logic [15:0] i);
		return mdl.exists(i) ? mdl[i] : 8'h00;
	endfunction : ev
	// one single transfer; starts and ends just after a rising edge
	task automatic ahb(input logic wr, input logic [15:0] i, input logic [7:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		hwrite <= wr;
		htrans <= abu_pkg::HTRANS_NONSEQ;
		haddr <= {14'h0, i, 2'h0};
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(negedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		@(posedge hclk);
	endtask : ahb
	// write and update the model
	task automatic put(input logic [15:0] i, input logic [7:0] d);
		logic [31:0] r;
		ahb(1'b1, i, d, r);
		case (i)
			16'hfe0c, 16'hfe0d: mdl[i] = d; // plain bytes
			16'hfe0e: mdl[i] = d & 8'hc0; // low bits read zero
			16'hfe0f: mdl[i] = d & 8'h80;
			16'hfe10: mdl[i] = ev(i) & d & 8'h02; // write zero clears
			16'hfe11: mdl[i] = ev(i) & ~d & 8'h07; // write one clears
			16'hfe12: mdl[i] = d & 8'h07;
			default: ; // unmapped place ignored
		endcase
	endtask : put
	// read every register plus one unmapped place, then the interrupt
	task automatic chk_all();
		logic [31:0] r;
		for (int i = 16'hfe0c; i <= 16'hfe13; i++) begin
			ahb(1'b0, 16'(i), 8'h0, r);
			`CHK(r, {24'h0, ev(16'(i))})
		end
		@(negedge hclk);
		`CHK({hresp, irq}, {1'b0, |(ev(16'hfe11) & ev(16'hfe12))})
		@(posedge hclk);
	endtask : chk_all
	task automatic fetch(input logic [15:0] a);
		fa <= a;
		fon <= 1'b1;
		@(posedge hclk);
		fon <= 1'b0;
	endtask : fetch
	task automatic quiet();
		repeat (6) begin
			@(negedge hclk);
			`CHK(break_request, 1'b0)
		end
		@(posedge hclk);
	endtask : quiet
	// follow one break from request to return
	task automatic brk(input logic [7:0] e, input logic fce);
		int n;
		n = 0;
		do begin @(negedge hclk); n++; end while (break_request !== 1'b1 && n < 4);
		`CHK(break_request, 1'b1)
		mdl[16'hfe0e] = ev(16'hfe0e) | 8'h40;
		mdl[16'hfe11] = ev(16'hfe11) | e;
		if (e[2]) mdl[16'hfe10] = 8'h02;
		n = 0;
		do begin @(negedge hclk); n++; end while (timer_stop !== 1'b1 && n < 12);
		`CHK(timer_stop, 1'b1)
		`CHK(watchdog_disable, tv)
		`CHK(flag_clear_allow, fce)
		`CHK(cpu_m.pc_q, mon ? 16'hfefc : 16'hfffc)
		`CHK(irq, |(ev(16'hfe11) & ev(16'hfe12)))
		n = 0;
		do begin @(negedge hclk); n++; end while (timer_stop !== 1'b0 && n < 12);
		`CHK({timer_stop, watchdog_disable, flag_clear_allow}, 3'b001)
		@(posedge hclk);
	endtask : brk
	task automatic end_of_test();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] a;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_all();
		for (int k = 0; k < 3; k++) begin
			lf = lfsr(lf);
			a = lf;
			slow <= k[0];
			mon <= k[1];
			tv <= k[0];
			put(16'hfe0c, a[15:8]);
			put(16'hfe0d, a[7:0]);
			put(16'hfe0e, 8'hbf);
			put(16'hfe0f, {k[1], 7'h7f});
			put(16'hfe12, 8'h07);
			fetch(a ^ (16'h1 << (k * 7)));
			quiet();
			fetch(a);
			brk(8'h01, k[1]);
			chk_all();
			put(16'hfe0e, 8'h80);
			put(16'hfe11, 8'h07);
			chk_all();
		end
		put(16'hfe0e, 8'h00);
		fetch(a);
		quiet();
		put(16'hfe0e, 8'h80);
		son <= 1'b1;
		fetch(a);
		quiet();
		son <= 1'b0;
		chk_all();
		put(16'hfe0e, 8'hc0);
		brk(8'h02, 1'b1);
		put(16'hfe0e, 8'h80);
		put(16'hfe12, 8'h00);
		won <= 1'b1;
		fetch(a);
		brk(8'h05, 1'b1);
		won <= 1'b0;
		chk_all();
		put(16'hfe12, 8'h04);
		chk_all();
		put(16'hfe10, 8'h00);
		put(16'hfe11, 8'h07);
		chk_all();
		end_of_test();
	end
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end
endmodule : address_breakpoint_unit_bench
